// >>> design/glitch_filter.sv
// Persistence filter that passes only changes lasting longer than a cycle limit
`default_nettype none

module glitch_filter #(
  parameter int COUNT_W = 10
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Raw input and delay in cycles
  input  wire logic               raw,
  input  wire logic [COUNT_W-1:0] limit,
  // Filtered output
  output var  logic               filtered
);

  logic [COUNT_W-1:0] count_q;
  logic               differ;
  logic               expired;

  assign differ  = raw != filtered;
  assign expired = count_q >= limit;

  // ----------------------------------------------------------------------------
  // Persistence counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (!differ || expired) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + 1'b1;
    end
  end

  // A change must outlast the limit before it is passed on
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      filtered <= 1'b0;
    end else if (differ && expired) begin
      filtered <= raw;
    end
  end

  a_change_after_limit: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(filtered) |-> $past(count_q) >= $past(limit) && $past(differ))
    else $error("filtered output changed before the delay ran out");

  a_zero_delay_follow: assert property (@(posedge clk) disable iff (!reset_n)
    limit == '0 && differ |=> filtered == $past(raw))
    else $error("zero delay did not pass the input at once");

endmodule : glitch_filter

`default_nettype wire

// >>> design/supply_fault_detector_cfg.sv
// Register bank and fault decision for one dual function supervised input
// Function
// - Hold writable over threshold, compare level.
// - Over condition lowers threshold by hysteresis.
// - Hold writable under threshold, compare level.
// - Under condition raises threshold by hysteresis.
// - Filter code selects 0 to 100 us.
// - Type code picks over, either, under, off.
// - Code 00 detector fault, 01 input fault.
// - Code 10 input fault, detector warning.
// - Code 11 gives no fault, no warning.
// - Detector pulses shorter than filter delay are ignored.
`default_nettype none
`include "supply_fault_map.svh"

module supply_fault_detector_cfg #(
  parameter int COUNT_W = 10
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_read,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rdata_valid,
  // Supervised level and logic input
  input  wire logic [7:0] supply_level,
  input  wire logic       general_purpose_input,
  // Conditions and decisions
  output var  logic       overvoltage_condition,
  output var  logic       undervoltage_condition,
  output var  logic       fault_out,
  output var  logic       warning_out
);

  import supply_fault_pkg::*;

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic write_to(input logic [7:0] offset);
    write_to = reg_write && (reg_addr == offset);
  endfunction : write_to

  function automatic logic [COUNT_W-1:0] delay_cycles(input logic [2:0] code);
    delay_cycles = '0;
    unique case (code)
      3'h0: delay_cycles = COUNT_W'(`FILTER_DELAY_0_US * `CLK_FREQ_MHZ);
      3'h1: delay_cycles = COUNT_W'(`FILTER_DELAY_1_US * `CLK_FREQ_MHZ);
      3'h2: delay_cycles = COUNT_W'(`FILTER_DELAY_2_US * `CLK_FREQ_MHZ);
      3'h3: delay_cycles = COUNT_W'(`FILTER_DELAY_3_US * `CLK_FREQ_MHZ);
      3'h4: delay_cycles = COUNT_W'(`FILTER_DELAY_4_US * `CLK_FREQ_MHZ);
      3'h5: delay_cycles = COUNT_W'(`FILTER_DELAY_5_US * `CLK_FREQ_MHZ);
      3'h6: delay_cycles = COUNT_W'(`FILTER_DELAY_6_US * `CLK_FREQ_MHZ);
      3'h7: delay_cycles = COUNT_W'(`FILTER_DELAY_7_US * `CLK_FREQ_MHZ);
    endcase
  endfunction : delay_cycles

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [7:0]          overvoltage_threshold_code_q;
  logic [4:0]          over_hysteresis_code_q;
  logic [7:0]          undervoltage_threshold_code_q;
  logic [4:0]          under_hysteresis_code_q;
  logic [2:0]          glitch_filter_delay_q;
  fault_type_type      fault_type_select_q;
  function_select_type function_select_q;
  logic [6:0]          general_cfg_q;

  logic [COUNT_W-1:0]  filter_limit;
  logic                detect_raw;
  logic                detect_filtered;
  logic                detect_active;
  logic                general_input_q;
  logic [7:0]          rdata_d;

  // Thresholds and hysteresis
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overvoltage_threshold_code_q  <= `OVER_THRESHOLD_RST;
      over_hysteresis_code_q        <= `HYST_RST;
      undervoltage_threshold_code_q <= `UNDER_THRESHOLD_RST;
      under_hysteresis_code_q       <= `HYST_RST;
    end else begin
      if (write_to(`OVER_THRESHOLD_ADDR)) begin
        overvoltage_threshold_code_q <= reg_wdata;
      end
      if (write_to(`OVER_HYST_ADDR)) begin
        over_hysteresis_code_q <= reg_wdata[`HYST_MSB:0];
      end
      if (write_to(`UNDER_THRESHOLD_ADDR)) begin
        undervoltage_threshold_code_q <= reg_wdata;
      end
      if (write_to(`UNDER_HYST_ADDR)) begin
        under_hysteresis_code_q <= reg_wdata[`HYST_MSB:0];
      end
    end
  end

  // Detector, function and logic input configuration
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      glitch_filter_delay_q <= `FILTER_DELAY_RST;
      fault_type_select_q   <= FT_OFF;
      function_select_q     <= FS_NONE;
      general_cfg_q         <= `GENERAL_CFG_RST;
    end else begin
      if (write_to(`DETECTOR_CFG_ADDR)) begin
        glitch_filter_delay_q <= reg_wdata[`FILTER_DELAY_MSB:`FILTER_DELAY_LSB];
        fault_type_select_q   <= fault_type_type'(reg_wdata[`FAULT_TYPE_MSB:0]);
      end
      if (write_to(`FUNCTION_SELECT_ADDR)) begin
        function_select_q <= function_select_type'(reg_wdata[`FUNCTION_SELECT_MSB:0]);
      end
      if (write_to(`GENERAL_CFG_ADDR)) begin
        general_cfg_q <= reg_wdata[`GENERAL_CFG_MSB:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------------------
  // Unimplemented bits are padded with zero, so software gains nothing from them
  always_comb begin
    unique case (reg_addr)
      `OVER_THRESHOLD_ADDR:  rdata_d = overvoltage_threshold_code_q;
      `OVER_HYST_ADDR:       rdata_d = {3'h0, over_hysteresis_code_q};
      `UNDER_THRESHOLD_ADDR: rdata_d = undervoltage_threshold_code_q;
      `UNDER_HYST_ADDR:      rdata_d = {3'h0, under_hysteresis_code_q};
      `DETECTOR_CFG_ADDR:    rdata_d = {3'h0, glitch_filter_delay_q, fault_type_select_q};
      `FUNCTION_SELECT_ADDR: rdata_d = {6'h00, function_select_q};
      `GENERAL_CFG_ADDR:     rdata_d = {1'b0, general_cfg_q};
      default:               rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata       <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_read;
      if (reg_read) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------------------
  threshold_compare #(
    .ABOVE (1'b1)
  ) over_compare (
    .clk        (clk),
    .reset_n    (reset_n),
    .level      (supply_level),
    .threshold  (overvoltage_threshold_code_q),
    .hysteresis (over_hysteresis_code_q),
    .condition  (overvoltage_condition)
  );

  threshold_compare #(
    .ABOVE (1'b0)
  ) under_compare (
    .clk        (clk),
    .reset_n    (reset_n),
    .level      (supply_level),
    .threshold  (undervoltage_threshold_code_q),
    .hysteresis (under_hysteresis_code_q),
    .condition  (undervoltage_condition)
  );

  // ----------------------------------------------------------------------------
  // Detector selection and filter
  // ----------------------------------------------------------------------------
  always_comb begin
    unique case (fault_type_select_q)
      FT_OVER:   detect_raw = overvoltage_condition;
      FT_EITHER: detect_raw = overvoltage_condition | undervoltage_condition;
      FT_UNDER:  detect_raw = undervoltage_condition;
      FT_OFF:    detect_raw = 1'b0;
    endcase
  end

  assign filter_limit = delay_cycles(glitch_filter_delay_q);

  glitch_filter #(
    .COUNT_W (COUNT_W)
  ) detect_filter (
    .clk      (clk),
    .reset_n  (reset_n),
    .raw      (detect_raw),
    .limit    (filter_limit),
    .filtered (detect_filtered)
  );

  // The filter may still drain a stale high after a switch to off, so gate it here
  assign detect_active = detect_filtered && (fault_type_select_q != FT_OFF);

  // ----------------------------------------------------------------------------
  // Role of the input
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      general_input_q <= 1'b0;
    end else begin
      general_input_q <= general_purpose_input;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fault_out   <= 1'b0;
      warning_out <= 1'b0;
    end else begin
      unique case (function_select_q)
        FS_DETECTOR: begin
          fault_out   <= detect_active;
          warning_out <= 1'b0;
        end
        FS_GENERAL: begin
          fault_out   <= general_input_q;
          warning_out <= 1'b0;
        end
        FS_GENERAL_WARN: begin
          fault_out   <= general_input_q;
          warning_out <= detect_active;
        end
        FS_NONE: begin
          fault_out   <= 1'b0;
          warning_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence over_threshold_written;
    write_to(`OVER_THRESHOLD_ADDR);
  endsequence

  sequence over_threshold_read;
    reg_read && !reg_write && reg_addr == `OVER_THRESHOLD_ADDR;
  endsequence

  a_threshold_readback: assert property (
    over_threshold_written ##1 !write_to(`OVER_THRESHOLD_ADDR) ##1 over_threshold_read |=> reg_rdata == $past(reg_wdata, 3))
    else $error("over threshold did not read back the written code");

  a_hyst_upper_zero: assert property (
    reg_read && reg_addr == `UNDER_HYST_ADDR |=> reg_rdata[7:5] == 3'h0 && reg_rdata_valid)
    else $error("unimplemented hysteresis bits read nonzero");

  a_unmapped_zero: assert property (
    reg_read && reg_addr > `GENERAL_CFG_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  a_slowest_filter: assert property (
    glitch_filter_delay_q == 3'h7 |-> filter_limit == COUNT_W'(1000))
    else $error("slowest filter code does not give 100 us");

  a_type_either: assert property (
    fault_type_select_q == FT_EITHER && undervoltage_condition |-> detect_raw)
    else $error("either type missed an under condition");

  a_type_off_quiet: assert property (
    fault_type_select_q == FT_OFF && function_select_q == FS_DETECTOR |=> !fault_out)
    else $error("detector reported a fault while switched off");

  a_detector_fault: assert property (
    function_select_q == FS_DETECTOR |=> fault_out == $past(detect_active) && !warning_out)
    else $error("detector role not on the fault output");

  a_general_fault: assert property (
    function_select_q == FS_GENERAL && $stable(function_select_q)
      |=> fault_out == $past(general_purpose_input, 2))
    else $error("logic input role not on the fault output");

  a_warning_role: assert property (
    function_select_q == FS_GENERAL_WARN
      |=> warning_out == $past(detect_active) && fault_out == $past(general_input_q))
    else $error("warning role does not follow the detector");

  a_no_role: assert property (
    function_select_q == FS_NONE [*2] |-> !fault_out && !warning_out)
    else $error("input without a role drove fault or warning");

endmodule : supply_fault_detector_cfg

`default_nettype wire

// >>> design/supply_fault_map.svh
// Register offsets, field positions, reset values and timing figures of the detector bank
`ifndef SUPPLY_FAULT_MAP_SVH
`define SUPPLY_FAULT_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OVER_THRESHOLD_ADDR   8'h40
`define OVER_HYST_ADDR        8'h41
`define UNDER_THRESHOLD_ADDR  8'h42
`define UNDER_HYST_ADDR       8'h43
`define DETECTOR_CFG_ADDR     8'h44
`define FUNCTION_SELECT_ADDR  8'h45
`define GENERAL_CFG_ADDR      8'h46

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define HYST_MSB              4
`define FILTER_DELAY_MSB      4
`define FILTER_DELAY_LSB      2
`define FAULT_TYPE_MSB        1
`define FUNCTION_SELECT_MSB   1
`define GENERAL_CFG_MSB       6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OVER_THRESHOLD_RST    8'hFF
`define UNDER_THRESHOLD_RST   8'h00
`define HYST_RST              5'h00
`define FILTER_DELAY_RST      3'h0
`define GENERAL_CFG_RST       7'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_MHZ          10
`define FILTER_DELAY_0_US     0
`define FILTER_DELAY_1_US     5
`define FILTER_DELAY_2_US     10
`define FILTER_DELAY_3_US     20
`define FILTER_DELAY_4_US     30
`define FILTER_DELAY_5_US     50
`define FILTER_DELAY_6_US     75
`define FILTER_DELAY_7_US     100

`endif

// >>> design/supply_fault_pkg.sv
// Types shared by the supply fault detector bank
`default_nettype none

package supply_fault_pkg;

  typedef enum logic [1:0] {
    FT_OVER   = 2'b00,
    FT_EITHER = 2'b01,
    FT_UNDER  = 2'b10,
    FT_OFF    = 2'b11
  } fault_type_type;

  typedef enum logic [1:0] {
    FS_DETECTOR     = 2'b00,
    FS_GENERAL      = 2'b01,
    FS_GENERAL_WARN = 2'b10,
    FS_NONE         = 2'b11
  } function_select_type;

endpackage : supply_fault_pkg

`default_nettype wire

// >>> design/threshold_compare.sv
// Threshold comparator with hysteresis for one supervised condition
`default_nettype none

module threshold_compare #(
  parameter bit ABOVE = 1'b1
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Supervised level and settings
  input  wire logic [7:0] level,
  input  wire logic [7:0] threshold,
  input  wire logic [4:0] hysteresis,
  // Condition
  output var  logic       condition
);

  logic [8:0] level_w;
  logic [8:0] thr_w;
  logic       enter_ok;
  logic       hold_ok;

  assign level_w = {1'b0, level};
  assign thr_w   = {1'b0, threshold};

  // Sums avoid the wrap that a subtracted threshold would suffer
  always_comb begin
    if (ABOVE) begin
      enter_ok = level_w > thr_w;
      hold_ok  = (level_w + 9'(hysteresis)) > thr_w;
    end else begin
      enter_ok = level_w < thr_w;
      hold_ok  = level_w < (thr_w + 9'(hysteresis));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      condition <= 1'b0;
    end else begin
      condition <= condition ? hold_ok : enter_ok;
    end
  end

  a_enter_cross: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(condition) |-> $past(enter_ok))
    else $error("condition rose without crossing the threshold");

  a_hyst_keeps: assert property (@(posedge clk) disable iff (!reset_n)
    condition && hold_ok |=> condition)
    else $error("condition dropped inside the hysteresis band");

  a_leave_band: assert property (@(posedge clk) disable iff (!reset_n)
    condition && !hold_ok |=> !condition)
    else $error("condition held outside the hysteresis band");

endmodule : threshold_compare

`default_nettype wire

// >>> test/supply_fault_detector_cfg_bench.sv
// Self-checking bench for the supply fault detector register bank
`default_nettype none
`include "supply_fault_map.svh"

module supply_fault_detector_cfg_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import supply_fault_pkg::*;

  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic       clk;
  logic       reset_n;
  logic [7:0] reg_addr;
  logic       reg_write;
  logic [7:0] reg_wdata;
  logic       reg_read;
  logic [7:0] reg_rdata;
  logic       reg_rdata_valid;
  logic [7:0] supply_level;
  logic       general_purpose_input;
  logic       overvoltage_condition;
  logic       undervoltage_condition;
  logic       fault_out;
  logic       warning_out;
  int         errors;
  int         comparisons;
  int         delay_us [8] = '{0, 5, 10, 20, 30, 50, 75, 100};
  logic [7:0] rst_val  [8] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00};
  logic [7:0] mask_val [8] = '{8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'h1F, 8'h03, 8'h7F, 8'h00};

  supply_fault_detector_cfg i_supply_fault_detector_cfg (
    .clk                    (clk),
    .reset_n                (reset_n),
    .reg_addr               (reg_addr),
    .reg_write              (reg_write),
    .reg_wdata              (reg_wdata),
    .reg_read               (reg_read),
    .reg_rdata              (reg_rdata),
    .reg_rdata_valid        (reg_rdata_valid),
    .supply_level           (supply_level),
    .general_purpose_input  (general_purpose_input),
    .overvoltage_condition  (overvoltage_condition),
    .undervoltage_condition (undervoltage_condition),
    .fault_out              (fault_out),
    .warning_out            (warning_out)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expected);
    comparisons++;
    if (seen !== expected) begin
      errors++;
      $display("Error %s expected %h seen %h", name, expected, seen);
    end
  endtask : check

  task automatic check_bit(input string name, input logic seen, input logic expected);
    check(name, {15'h0000, seen}, {15'h0000, expected});
  endtask : check_bit

  // Inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Strobes drop and an edge passes, so back-to-back calls never re-raise in one step
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    reg_addr  = addr;
    reg_wdata = data;
    reg_write = 1'b1;
    step(1);
    reg_write = 1'b0;
    step(1);
  endtask : write_reg

  task automatic read_check(input logic [7:0] addr, input logic [7:0] expected);
    reg_addr = addr;
    reg_read = 1'b1;
    step(1);
    reg_read = 1'b0;
    check_bit("read valid", reg_rdata_valid, 1'b1);
    check("read data", {8'h00, reg_rdata}, {8'h00, expected});
    step(1);
    check_bit("read valid drop", reg_rdata_valid, 1'b0);
  endtask : read_check

  task automatic wait_fault(input logic v);
    int n;
    n = 0;
    while (fault_out !== v && n < 1100) begin
      step(1);
      n++;
    end
    check_bit("fault settle", fault_out, v);
  endtask : wait_fault

  task automatic final_report;
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // Longest run is well under this; a hang lands here
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report();
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] pat;
    logic       ov;
    logic       uv;
    logic       hit;
    int         n;
    int         lim;
    errors = 0;
    comparisons = 0;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
    supply_level = 8'h60;
    general_purpose_input = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    reset_n = 1'b1;
    check_bit("fault after reset", fault_out, 1'b0);
    // Reset values, then two patterns with unused bits set; 0x47 is unmapped
    for (int i = 0; i < 8; i++) begin
      a = 8'(8'h40 + i);
      read_check(a, rst_val[i]);
    end
    read_check(8'h3F, 8'h00);
    for (int p = 0; p < 2; p++) begin
      pat = (p == 0) ? 8'hFF : 8'hA5;
      for (int i = 0; i < 8; i++) write_reg(8'(8'h40 + i), pat);
      for (int i = 0; i < 8; i++) read_check(8'(8'h40 + i), pat & mask_val[i]);
    end
    // Thresholds with hysteresis, type either, detector only, no filter
    write_reg(`OVER_THRESHOLD_ADDR, 8'h80);
    read_check(`OVER_THRESHOLD_ADDR, 8'h80);
    write_reg(`OVER_HYST_ADDR, 8'h04);
    write_reg(`UNDER_THRESHOLD_ADDR, 8'h40);
    write_reg(`UNDER_HYST_ADDR, 8'h04);
    write_reg(`DETECTOR_CFG_ADDR, {6'h00, FT_EITHER});
    write_reg(`FUNCTION_SELECT_ADDR, {6'h00, FS_DETECTOR});
    supply_level = 8'h80;
    step(3);
    check_bit("over at equal", overvoltage_condition, 1'b0);
    supply_level = 8'h81;
    step(1);
    check_bit("over set", overvoltage_condition, 1'b1);
    step(2);
    check_bit("over fault", fault_out, 1'b1);
    supply_level = 8'h7D;
    step(3);
    check_bit("over held", overvoltage_condition, 1'b1);
    supply_level = 8'h7C;
    step(1);
    check_bit("over clear", overvoltage_condition, 1'b0);
    supply_level = 8'h40;
    step(3);
    check_bit("under at equal", undervoltage_condition, 1'b0);
    supply_level = 8'h3F;
    step(1);
    check_bit("under set", undervoltage_condition, 1'b1);
    step(2);
    check_bit("under fault", fault_out, 1'b1);
    supply_level = 8'h43;
    step(3);
    check_bit("under held", undervoltage_condition, 1'b1);
    supply_level = 8'h44;
    step(1);
    check_bit("under clear", undervoltage_condition, 1'b0);
    // Every fault type against over, under and in-range levels
    for (int t = 0; t < 4; t++) begin
      write_reg(`DETECTOR_CFG_ADDR, {6'h00, 2'(t)});
      for (int l = 0; l < 3; l++) begin
        supply_level = (l == 0) ? 8'h90 : (l == 1) ? 8'h30 : 8'h60;
        ov = (l == 0);
        uv = (l == 1);
        step(4);
        check_bit("fault by type", fault_out,
                  (ov && (t == 0 || t == 1)) || (uv && (t == 1 || t == 2)));
      end
    end
    // Every function code against detector and logic input
    write_reg(`DETECTOR_CFG_ADDR, {6'h00, FT_OVER});
    for (int f = 0; f < 4; f++) begin
      write_reg(`FUNCTION_SELECT_ADDR, {6'h00, 2'(f)});
      for (int c = 0; c < 4; c++) begin
        supply_level = c[0] ? 8'h90 : 8'h60;
        general_purpose_input = c[1];
        step(5);
        check_bit("fault by function", fault_out,
                  (f == 0) ? c[0] : (f == 3) ? 1'b0 : c[1]);
        check_bit("warning by function", warning_out, (f == 2) && c[0]);
      end
    end
    general_purpose_input = 1'b0;
    // Delay to fault for each filter code
    write_reg(`FUNCTION_SELECT_ADDR, {6'h00, FS_DETECTOR});
    for (int g = 0; g < 8; g++) begin
      write_reg(`DETECTOR_CFG_ADDR, {3'h0, 3'(g), FT_OVER});
      supply_level = 8'h60;
      wait_fault(1'b0);
      lim = delay_us[g] * `CLK_FREQ_MHZ;
      supply_level = 8'h90;
      n = 0;
      while (fault_out !== 1'b1 && n < 1100) begin
        step(1);
        n++;
      end
      check("filter delay", 16'(n), 16'(lim + 3));
    end
    // Short pulse and short dip are both swallowed at 20 us
    write_reg(`DETECTOR_CFG_ADDR, {3'h0, 3'h3, FT_OVER});
    supply_level = 8'h60;
    wait_fault(1'b0);
    supply_level = 8'h90;
    step(150);
    supply_level = 8'h60;
    hit = 1'b0;
    for (int i = 0; i < 300; i++) begin
      step(1);
      if (fault_out !== 1'b0) hit = 1'b1;
    end
    check_bit("short pulse", hit, 1'b0);
    supply_level = 8'h90;
    wait_fault(1'b1);
    supply_level = 8'h60;
    step(150);
    supply_level = 8'h90;
    hit = 1'b0;
    for (int i = 0; i < 300; i++) begin
      step(1);
      if (fault_out !== 1'b1) hit = 1'b1;
    end
    check_bit("short dip", hit, 1'b0);
    final_report();
  end

endmodule : supply_fault_detector_cfg_bench

`default_nettype wire
